/* File: hw/seq_pkg.sv */
// constants shared by the regulator enable sequencer
package seq_pkg;

    // ------------------------------------------------------------
    // channel counts and clock
    // ------------------------------------------------------------
    localparam int NUM_SW  = 2;
    localparam int NUM_LIN = 2;
    localparam int NUM_REG = NUM_SW + NUM_LIN;
    localparam int NUM_CH  = NUM_REG + 2;
    localparam int CLK_HZ  = 50_000_000;

    // ------------------------------------------------------------
    // timing: times in their own unit, counts derived from them
    // ------------------------------------------------------------
    localparam int SHORT_TIME_US    = 1000;
    localparam int SHORT_CYCLES     = SHORT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int DELAY_STEP_US    = 1000;
    localparam int DELAY_STEP_CYC   = DELAY_STEP_US * (CLK_HZ / 1_000_000);
    localparam int RAMP_UNIT_NS     = 1000;
    localparam int RAMP_UNIT_CYC    = RAMP_UNIT_NS / (1_000_000_000 / CLK_HZ);
    localparam int CNT_W            = 20;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int SW_SET_W  = 8;
    localparam int LIN_SET_W = 5;
    localparam int DLY_W     = 4;
    localparam int RATE_W    = 3;
    localparam logic [CNT_W-1:0] CNT_RST = 20'h0_0000;
    localparam logic             BIT_RST = 1'b0;

    // ------------------------------------------------------------
    // reset sequence states, gray along run-hold-load-start
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_HOLD  = 2'b01,
        ST_LOAD  = 2'b11,
        ST_START = 2'b10
    } seq_state_type;

endpackage

/* File: hw/regulator_enable_sequencer.sv */
// enable sequencing, fault flags and reset handling for four regulators
`timescale 1ns/1ns

//
// Contract
// - enable bit low keeps the regulator off regardless of pin control
// - enable high, pin control low: regulator on at its set-point
// - enable and pin control high: regulator follows the enable pin
// - switcher below 0.35 V for 1 ms while on: disable, set short flag
// - linear below 0.3 V for 1 ms while on: disable, set short flag
// - output becoming valid sets good flag unless rise mask set
// - output becoming invalid sets good flag unless fall mask set
// - good state shows output validity at all times, unmasked
// - window select picks undervoltage only or both limits per group
// - a configuration bit switches the enable pin pulldown
// - switcher set-point change ramps at its slew-rate field
// - fixed frequency forced during ramp, then the fixed-freq bit rules
// - pin rising edge starts pin-controlled regulator after on delay
// - pin falling edge stops pin-controlled regulator after off delay
// - aux outputs follow the pin with their own on and off delays
// - delays apply only to pin edges, never to enable bit writes
// - soft reset self-clears, drops outputs, restores defaults, loads OTP
// - soft reset leaves the serial interface untouched
// - supply undervoltage drops all outputs and restores defaults
// - supply recovery runs power-on reset, OTP load, then start-up
// - interrupt pin low while any flag is pending
// - after fault or soft reset set reset flag unless OTP mask set
// - reset flag mask reloaded from OTP in every reset sequence
// - short and good flags clear on write-1, short has no mask
module regulator_enable_sequencer #(
    parameter int SHORT_CYC  = seq_pkg::SHORT_CYCLES,   // debounce count
    parameter int STEP_CYC   = seq_pkg::DELAY_STEP_CYC, // cycles per code
    parameter int RAMP_CYC   = seq_pkg::RAMP_UNIT_CYC   // ramp base period
) (
    input  wire logic                  ref_clk,                 // clock
    input  wire logic                  rst,                     // power-on
    input  wire logic                  ce,                      // clk enable
    input  wire logic                  enable_pin,              // shared pin
    input  wire logic                  uvlo,                    // supply low
    input  wire logic                  fault_shutdown,          // fault pulse
    input  wire logic                  soft_reset_bit,          // write-1
    input  wire logic                  otp_reset_mask,          // otp mask
    input  wire logic                  pin_pulldown_on,         // cfg bit
    input  wire logic [1:0]            switcher_on_bit,         // enable
    input  wire logic [1:0]            switcher_pin_follow_bit, // pin ctrl
    input  wire logic [1:0][7:0]       switcher_setpoint,       // voltage
    input  wire logic [1:0][2:0]       switcher_ramp_rate,      // slew code
    input  wire logic [1:0]            switcher_fixed_freq_bit, // fpwm
    input  wire logic [1:0][3:0]       switcher_on_delay,       // start
    input  wire logic [1:0][3:0]       switcher_off_delay,      // stop
    input  wire logic [1:0]            linear_reg_on_bit,         // enable
    input  wire logic [1:0]            linear_reg_pin_follow_bit, // pin ctrl
    input  wire logic [1:0][4:0]       linear_reg_setpoint,       // voltage
    input  wire logic [1:0][3:0]       linear_reg_on_delay,       // start
    input  wire logic [1:0][3:0]       linear_reg_off_delay,      // stop
    input  wire logic [1:0]            aux_output_on_bit,         // enable
    input  wire logic [1:0]            aux_output_pin_follow_bit, // pin ctrl
    input  wire logic [1:0][3:0]       aux_output_on_delay,       // rise
    input  wire logic [1:0][3:0]       aux_output_off_delay,      // fall
    input  wire logic [3:0]            out_above_short,   // sw0,sw1,l0,l1
    input  wire logic [3:0]            out_uv_ok,         // above uv limit
    input  wire logic [3:0]            out_ov_ok,         // below ov limit
    input  wire logic                  switcher_window_select,   // 1: both
    input  wire logic                  linear_reg_window_select, // 1: both
    input  wire logic [3:0]            good_rise_mask,    // per regulator
    input  wire logic [3:0]            good_fall_mask,    // per regulator
    input  wire logic [3:0]            short_flag_clear,  // write-1 pulses
    input  wire logic [3:0]            good_flag_clear,   // write-1 pulses
    input  wire logic                  reset_flag_clear,  // write-1 pulse
    output logic      [1:0]            switcher_enable,   // regulator on
    output logic      [1:0][7:0]       switcher_level,    // ramped target
    output logic      [1:0]            switcher_fixed_freq, // force pwm
    output logic      [1:0]            linear_reg_enable, // regulator on
    output logic      [1:0][4:0]       linear_reg_level,  // target
    output logic                       aux_output_a,      // gpo a
    output logic                       aux_output_b,      // gpo b
    output logic      [3:0]            short_flag,        // sticky
    output logic      [3:0]            good_flag,         // sticky
    output logic      [3:0]            good_state,        // validity
    output logic                       reset_flag,        // sticky
    output logic                       reset_mask,        // from otp
    output logic                       pulldown_enable,   // pin pulldown
    output logic                       defaults_restore,  // regs to reset
    output logic                       otp_load,          // otp strobe
    output logic                       irq_pin_low_active_out, // always 0
    output logic                       irq_pin_low_active_oe   // pulls low
);

    localparam int CH = seq_pkg::NUM_CH;
    localparam int NR = seq_pkg::NUM_REG;
    localparam int CW = seq_pkg::CNT_W;

    // ------------------------------------------------------------
    // reset sequence
    // ------------------------------------------------------------
    seq_pkg::seq_state_type state_reg;
    logic                   run;
    logic                   hold;
    logic                   cause_reg;

    assign run              = (state_reg == seq_pkg::ST_RUN);
    assign hold             = (state_reg == seq_pkg::ST_HOLD);
    assign defaults_restore = hold;
    assign otp_load         = (state_reg == seq_pkg::ST_LOAD);

    // undervoltage wins over everything; soft reset is a one-shot
    // strobe, so nothing here has to clear it afterwards
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= seq_pkg::ST_HOLD;
        end else if (ce) begin
            if (uvlo) begin
                state_reg <= seq_pkg::ST_HOLD;
            end else begin
                unique case (state_reg)
                    seq_pkg::ST_RUN: begin
                        if (soft_reset_bit || fault_shutdown) begin
                            state_reg <= seq_pkg::ST_HOLD;
                        end
                    end
                    seq_pkg::ST_HOLD:  state_reg <= seq_pkg::ST_LOAD;
                    seq_pkg::ST_LOAD:  state_reg <= seq_pkg::ST_START;
                    seq_pkg::ST_START: state_reg <= seq_pkg::ST_RUN;
                endcase
            end
        end
    end

    // reset cause survives the hold; start-up or power-on clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cause_reg <= seq_pkg::BIT_RST;
        end else if (ce) begin
            if (run && (soft_reset_bit || fault_shutdown)) begin
                cause_reg <= 1'b1;
            end else if (state_reg == seq_pkg::ST_START) begin
                cause_reg <= 1'b0;
            end
        end
    end

    // mask reloaded each sequence, host writes cannot reach it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_mask <= seq_pkg::BIT_RST;
        end else if (ce && otp_load) begin
            reset_mask <= otp_reset_mask;
        end
    end

    // reset indication, raised at start-up; set wins over clear
    always_ff @(posedge ref_clk) begin
        if (rst || (ce && hold)) begin
            reset_flag <= seq_pkg::BIT_RST;
        end else if (ce) begin
            if (state_reg == seq_pkg::ST_START && cause_reg
                && !reset_mask) begin
                reset_flag <= 1'b1;
            end else if (reset_flag_clear) begin
                reset_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // enable pin synchroniser and edges
    // ------------------------------------------------------------
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic pin_rise;
    logic pin_fall;

    // prev held low outside run so a pin already high counts as a rise
    // when the start-up after a reset comes round
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta_reg <= seq_pkg::BIT_RST;
            pin_sync_reg <= seq_pkg::BIT_RST;
            pin_prev_reg <= seq_pkg::BIT_RST;
        end else if (ce) begin
            pin_meta_reg <= enable_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= run ? pin_sync_reg : 1'b0;
        end
    end

    assign pin_rise = run && pin_sync_reg && !pin_prev_reg;
    assign pin_fall = run && !pin_sync_reg && pin_prev_reg;

    // pulldown follows its configuration bit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulldown_enable <= seq_pkg::BIT_RST;
        end else if (ce) begin
            pulldown_enable <= pin_pulldown_on;
        end
    end

    // ------------------------------------------------------------
    // per channel gathering: sw0 sw1 lin0 lin1 aux_a aux_b
    // ------------------------------------------------------------
    logic [CH-1:0]        on_all;
    logic [CH-1:0]        follow_all;
    logic [CH-1:0][3:0]   up_dly;
    logic [CH-1:0][3:0]   dn_dly;
    logic [CH-1:0]        pin_state;
    logic [CH-1:0]        en_reg;
    logic [NR-1:0]        trip_reg;
    logic [CH-1:0]        want;

    assign on_all     = {aux_output_on_bit, linear_reg_on_bit,
                         switcher_on_bit};
    assign follow_all = {aux_output_pin_follow_bit,
                         linear_reg_pin_follow_bit, switcher_pin_follow_bit};
    assign up_dly     = {aux_output_on_delay, linear_reg_on_delay,
                         switcher_on_delay};
    assign dn_dly     = {aux_output_off_delay, linear_reg_off_delay,
                         switcher_off_delay};

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            logic [CW-1:0] cnt_reg;
            logic          busy_reg;
            logic          tgt_reg;
            logic          ps_reg;

            // one delay counter per channel; a new edge restarts it
            always_ff @(posedge ref_clk) begin
                if (rst || (ce && !run)) begin
                    cnt_reg  <= seq_pkg::CNT_RST;
                    busy_reg <= seq_pkg::BIT_RST;
                    tgt_reg  <= seq_pkg::BIT_RST;
                    ps_reg   <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    if (pin_rise || pin_fall) begin
                        if ((pin_rise ? up_dly[g] : dn_dly[g]) == 4'h0) begin
                            ps_reg   <= pin_rise;
                            busy_reg <= 1'b0;
                        end else begin
                            cnt_reg  <= CW'(32'(pin_rise ? up_dly[g]
                                        : dn_dly[g]) * STEP_CYC);
                            busy_reg <= 1'b1;
                            tgt_reg  <= pin_rise;
                        end
                    end else if (busy_reg) begin
                        if (cnt_reg == CW'(1)) begin
                            ps_reg   <= tgt_reg;
                            busy_reg <= 1'b0;
                        end
                        cnt_reg <= cnt_reg - CW'(1);
                    end
                end
            end
            assign pin_state[g] = ps_reg;

            // enable bit writes act at once, only pin edges are delayed
            assign want[g] = on_all[g]
                           && (!follow_all[g] || ps_reg);

            // registered output enable, dropped at once outside run
            always_ff @(posedge ref_clk) begin
                if (rst || (ce && !run)) begin
                    en_reg[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    en_reg[g] <= want[g]
                              && !((g < NR) && trip_reg[g % NR]);
                end
            end
        end
    endgenerate

    assign switcher_enable   = en_reg[1:0];
    assign linear_reg_enable = en_reg[3:2];
    assign aux_output_a      = en_reg[4];
    assign aux_output_b      = en_reg[5];

    // ------------------------------------------------------------
    // short circuit and power good, one slice per regulator
    // ------------------------------------------------------------
    logic [NR-1:0] valid_reg;
    logic [NR-1:0] valid_now;

    generate
        for (g = 0; g < NR; g++) begin : g_reg
            logic [CW-1:0] low_reg;

            // a stuck-low output, at start-up or later, trips after
            // the debounce; the trip holds until the request drops
            always_ff @(posedge ref_clk) begin
                if (rst || (ce && !run)) begin
                    low_reg     <= seq_pkg::CNT_RST;
                    trip_reg[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    if (!want[g]) begin
                        trip_reg[g] <= 1'b0;
                    end
                    if (!en_reg[g] || out_above_short[g]) begin
                        low_reg <= seq_pkg::CNT_RST;
                    end else if (low_reg == CW'(SHORT_CYC - 1)) begin
                        low_reg     <= seq_pkg::CNT_RST;
                        trip_reg[g] <= 1'b1;
                    end else begin
                        low_reg <= low_reg + CW'(1);
                    end
                end
            end

            // sticky short flag, no mask; the set beats a clear
            always_ff @(posedge ref_clk) begin
                if (rst || (ce && hold)) begin
                    short_flag[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    if (en_reg[g] && !out_above_short[g]
                        && low_reg == CW'(SHORT_CYC - 1)) begin
                        short_flag[g] <= 1'b1;
                    end else if (short_flag_clear[g]) begin
                        short_flag[g] <= 1'b0;
                    end
                end
            end

            // validity by undervoltage alone or the full window
            assign valid_now[g] = out_uv_ok[g] &&
                (!((g < seq_pkg::NUM_SW) ? switcher_window_select
                   : linear_reg_window_select) || out_ov_ok[g]);

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    valid_reg[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    valid_reg[g] <= valid_now[g];
                end
            end

            // edges of validity raise the sticky good flag
            always_ff @(posedge ref_clk) begin
                if (rst || (ce && hold)) begin
                    good_flag[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    if ((valid_now[g] && !valid_reg[g]
                         && !good_rise_mask[g])
                        || (!valid_now[g] && valid_reg[g]
                         && !good_fall_mask[g])) begin
                        good_flag[g] <= 1'b1;
                    end else if (good_flag_clear[g]) begin
                        good_flag[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign good_state = valid_reg;

    // ------------------------------------------------------------
    // switcher set-point ramp and forced fixed frequency
    // ------------------------------------------------------------
    generate
        for (g = 0; g < seq_pkg::NUM_SW; g++) begin : g_ramp
            logic [CW-1:0] tick_reg;
            logic          ramping;

            // an off switcher snaps to target: its start is soft-start,
            // not the slew ramp. slower codes double the step period
            assign ramping = en_reg[g]
                           && (switcher_level[g] != switcher_setpoint[g]);

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    tick_reg          <= seq_pkg::CNT_RST;
                    switcher_level[g] <= '0;
                end else if (ce) begin
                    if (!ramping) begin
                        tick_reg          <= seq_pkg::CNT_RST;
                        switcher_level[g] <= switcher_setpoint[g];
                    end else if (tick_reg >= CW'(RAMP_CYC
                                 << (3'd7 - switcher_ramp_rate[g]))
                                 - CW'(1)) begin
                        tick_reg <= seq_pkg::CNT_RST;
                        if (switcher_level[g] < switcher_setpoint[g]) begin
                            switcher_level[g] <= switcher_level[g] + 8'd1;
                        end else begin
                            switcher_level[g] <= switcher_level[g] - 8'd1;
                        end
                    end else begin
                        tick_reg <= tick_reg + CW'(1);
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    switcher_fixed_freq[g] <= seq_pkg::BIT_RST;
                end else if (ce) begin
                    switcher_fixed_freq[g] <= en_reg[g]
                        && (ramping || switcher_fixed_freq_bit[g]);
                end
            end
        end
    endgenerate

    // linear target is applied directly; its good state may chatter
    // for a while after a change, which the host has to tolerate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            linear_reg_level <= '0;
        end else if (ce) begin
            linear_reg_level <= linear_reg_setpoint;
        end
    end

    // ------------------------------------------------------------
    // open-drain interrupt pin
    // ------------------------------------------------------------
    assign irq_pin_low_active_out = 1'b0;
    assign irq_pin_low_active_oe  = (|short_flag) || (|good_flag)
                                  || reset_flag;

endmodule

/* File: sim/seq_chk.sv */
// port checker for the regulator enable sequencer
`timescale 1ns/1ns
module seq_chk (
    input wire logic ref_clk, rst, aux_output_a, defaults_restore, reset_flag,
    input wire logic irq_pin_low_active_oe, pin_pulldown_on, pulldown_enable,
    input wire logic [1:0] switcher_on_bit, switcher_enable,
    input wire logic [1:0] linear_reg_on_bit, linear_reg_enable,
    input wire logic [3:0] short_flag, good_flag, good_state,
    input wire logic [3:0] good_rise_mask, good_fall_mask
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    bit_off_a: assert property (!switcher_on_bit[0] |=>
        !switcher_enable[0]) else $error("on while bit low");
    direct_on_a: assert property ($rose(linear_reg_enable[0]) |->
        $past(linear_reg_on_bit[0])) else $error("on without bit");
    irq_any_a: assert property (irq_pin_low_active_oe ==
        (|short_flag || |good_flag || reset_flag)) else $error("irq pin");
    pulldown_on_a: assert property ($rose(pin_pulldown_on) |=>
        pulldown_enable) else $error("pulldown");
    short_off_a: assert property ($rose(short_flag[0]) |=>
        !switcher_enable[0]) else $error("short kept on");
    rise_flag_a: assert property ($rose(good_state[2]) &&
        !$past(good_rise_mask[2]) |-> good_flag[2]) else $error("rise flag");
    fall_flag_a: assert property ($fell(good_state[2]) &&
        !$past(good_fall_mask[2]) |-> good_flag[2]) else $error("fall flag");
    soft_drop_a: assert property ($rose(defaults_restore) |=>
        !switcher_enable && !linear_reg_enable && !aux_output_a)
        else $error("outputs kept on");
endmodule
bind regulator_enable_sequencer seq_chk seq_chk_inst (.*);

/* File: sim/reg_output_model.sv */
// behavioural rails seen by the sequencer comparators
`timescale 1ns/1ns
module reg_output_model (
    input  wire logic [1:0] switcher_enable, linear_reg_enable, // requests
    input  wire logic [3:0] force_short, force_over,            // faults
    output logic      [3:0] out_above_short, out_uv_ok, out_ov_ok // levels
);
    // rails rise at once; a shorted rail fails the uv limit but still passes ov
    assign out_above_short = {linear_reg_enable, switcher_enable} & ~force_short;
    assign out_uv_ok = out_above_short;
    assign out_ov_ok = ~force_over;
endmodule

/* File: sim/tb_regulator_enable_sequencer.sv */
// self-checking bench for the regulator enable sequencer
`timescale 1ns/1ns
module tb_regulator_enable_sequencer;
    bit ref_clk, rst = 1, ce = 1, enable_pin, uvlo, fault_shutdown;
    bit otp_reset_mask, soft_reset_bit, pin_pulldown_on, reset_flag_clear;
    bit switcher_window_select, linear_reg_window_select;
    bit [1:0] switcher_on_bit, switcher_pin_follow_bit, linear_reg_on_bit;
    bit [1:0] switcher_fixed_freq_bit, linear_reg_pin_follow_bit;
    bit [1:0] aux_output_on_bit, aux_output_pin_follow_bit;
    bit [1:0][7:0] switcher_setpoint;
    bit [1:0][4:0] linear_reg_setpoint;
    bit [1:0][2:0] switcher_ramp_rate;
    bit [1:0][3:0] switcher_on_delay, switcher_off_delay, aux_output_on_delay;
    bit [1:0][3:0] linear_reg_on_delay, linear_reg_off_delay;
    bit [1:0][3:0] aux_output_off_delay;
    bit [3:0] good_rise_mask = 4'hb, good_fall_mask = 4'hb, force_short;
    bit [3:0] short_flag_clear, good_flag_clear, force_over;
    logic [3:0] out_above_short, out_uv_ok, out_ov_ok, short_flag, good_flag;
    logic [3:0] good_state;
    logic [1:0] switcher_enable, switcher_fixed_freq, linear_reg_enable;
    logic [1:0][7:0] switcher_level;
    logic [1:0][4:0] linear_reg_level;
    logic aux_output_a, aux_output_b, reset_flag, reset_mask, defaults_restore;
    logic pulldown_enable, otp_load, irq_pin_low_active_out;
    logic irq_pin_low_active_oe;
    int fails, tests_run;
    // short counts keep the run brief; delay code n is n*4 cycles
    regulator_enable_sequencer #(.SHORT_CYC(20), .STEP_CYC(4), .RAMP_CYC(1))
        regulator_enable_sequencer_inst (.*);
    reg_output_model reg_output_model_inst (.*);
    always #10 ref_clk = ~ref_clk;
    task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // sw0 direct, sw1 and aux a follow the pin with their own delays
    task automatic t_pin;
        @(posedge ref_clk) switcher_on_bit <= 3; switcher_pin_follow_bit <= 2;
        switcher_on_delay[1] <= 2; switcher_off_delay[1] <= 1;
        aux_output_on_bit <= 1; aux_output_pin_follow_bit <= 1;
        @(posedge ref_clk) enable_pin <= 1; pin_pulldown_on <= 1;
        switcher_ramp_rate[0] <= 5;
        tick(6); chk("aux", 1, 4'(aux_output_a));
        chk("sw", 1, 4'(switcher_enable));
        tick(4); chk("sw", 1, 4'(switcher_enable));
        tick(3); chk("sw", 3, 4'(switcher_enable));
        @(posedge ref_clk) enable_pin <= 0; switcher_setpoint[0] <= 2;
        tick(6); chk("aux", 0, 4'(aux_output_a));
        chk("sw", 3, 4'(switcher_enable));
        chk("pwm", 1, 4'(switcher_fixed_freq));
        tick(4); chk("sw", 1, 4'(switcher_enable));
        chk("lvl", 2, 4'(switcher_level[0]));
        chk("pwm", 0, 4'(switcher_fixed_freq));
        $display("done pin");
    endtask
    // sw0 held below the short level until it trips
    task automatic t_short;
        int n;
        @(posedge ref_clk) force_short <= 1;
        for (n = 0; n < 60 && short_flag[0] !== 1'b1; n++) tick(1);
        chk("short", 1, short_flag); chk("wait", 1, 4'(n >= 18));
        if (n == 60) end_of_test;
        tick(1); chk("sw", 0, 4'(switcher_enable));
        chk("irq", 1, 4'(irq_pin_low_active_oe));
        @(posedge ref_clk) short_flag_clear <= 1; switcher_on_bit <= 0;
        @(posedge ref_clk) short_flag_clear <= 0;
        tick(1); chk("short", 0, short_flag);
        $display("done short");
    endtask
    task automatic clr_good;
        @(posedge ref_clk) good_flag_clear <= 4;
        @(posedge ref_clk) good_flag_clear <= 0;
        tick(1); chk("flag", 0, good_flag);
    endtask
    // lin0 valid, then over its window, then window narrowed to uv only
    task automatic t_good;
        @(posedge ref_clk) linear_reg_on_bit <= 1; linear_reg_setpoint[0] <= 3;
        tick(3); chk("good", 4, good_state); chk("flag", 4, good_flag);
        chk("llvl", 3, 4'(linear_reg_level[0]));
        clr_good;
        @(posedge ref_clk) linear_reg_window_select <= 1; force_over <= 4;
        tick(3); chk("good", 0, good_state); chk("flag", 4, good_flag);
        clr_good;
        @(posedge ref_clk) linear_reg_window_select <= 0;
        good_rise_mask <= 15; good_fall_mask <= 15;
        tick(3); chk("good", 4, good_state); chk("flag", 0, good_flag);
        $display("done good");
    endtask
    task automatic t_soft;
        @(posedge ref_clk) soft_reset_bit <= 1;
        @(posedge ref_clk) soft_reset_bit <= 0;
        tick(2); chk("lin", 0, 4'(linear_reg_enable));
        tick(6); chk("rflag", 1, 4'(reset_flag));
        chk("lin", 1, 4'(linear_reg_enable));
        @(posedge ref_clk) reset_flag_clear <= 1;
        @(posedge ref_clk) reset_flag_clear <= 0;
        tick(1); chk("irq", 0, 4'(irq_pin_low_active_oe));
        @(posedge ref_clk) uvlo <= 1;
        @(posedge ref_clk) uvlo <= 0;
        tick(2); chk("lin", 0, 4'(linear_reg_enable));
        tick(6); chk("lin", 1, 4'(linear_reg_enable));
        $display("done soft reset");
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        tick(5); t_pin; t_short; t_good; t_soft;
        end_of_test;
    end
endmodule
